// ==== hw/kbd_scan_defs.vh ====
// Constants for the keyboard matrix scanner: offsets, field positions, resets.
// Assumes inclusion by bare name from the design file.
`ifndef KBD_SCAN_DEFS_VH
`define KBD_SCAN_DEFS_VH
`define ROW_COUNT 18
`define COL_COUNT 8
`define OFS_RESERVED 6'h00
`define OFS_ROW_SELECT 6'h04
`define OFS_COL_LEVEL 6'h08
`define OFS_COL_STATUS 6'h0C
`define OFS_COL_ENABLE 6'h10
`define OFS_EXT_CONTROL 6'h14
`define SEL_LSB 0
`define SEL_MSB 4
`define ALL_ROWS_BIT 5
`define SCAN_DIS_BIT 6
`define POLARITY_BIT 7
`define PREDRIVE_BIT 0
`define SEL_LAST_ROW 5'h11
`define ROW_SELECT_RESET 8'h40
// Predrive lasts 16 ns, which is two block clocks.
`define PREDRIVE_CYCLES 5'h02
`endif

// ==== hw/keyboard_matrix_scanner.v ====
// Keyboard matrix scanner: firmware row drive, column sampling, edge status,
// runtime interrupt and wake request.
// Assumes a simple synchronous register port from the embedded processor and
// pull-ups on every row and column pin.
//
// Summary of operation
// - At most eighteen rows, eight columns.
// - Eight-bit column input, eighteen-bit row output.
// - All scan logic on the block clock.
// - Reset returns all state to defaults.
// - Low power when idle or scan disabled.
// - Hold off chip sleep only while scanning.
// - One row driven low, zero means pressed.
// - Predrive drives row high before release.
// - Predrive enable bit in extended control.
// - Falling edge sets column status, on the block clock.
// - Column request is status AND enable.
// - Write one clears status, zero keeps.
// - Column requests ORed into runtime interrupt.
// - No reassert until columns high or change.
// - Sleep edge raises wake until clock runs.
// - Sleep edge pulses clock-request status set.
// - Sleep edge sets status, irq on resume.
// - Registers at offsets 4h through 14h.
// - Scan-disable resets one, turns buffers off.
// - Five-bit select or all-rows bit.
// - Polarity bit sets active row level.
`timescale 1ns/1ns
`default_nettype none
`include "kbd_scan_defs.vh"
module keyboard_matrix_scanner (
  // Clock and reset
  input wire clock_i,
  input wire sys_rst_i,
  // Register port
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [5:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  output reg [31:0] reg_rdata_o,
  // Matrix pins
  input wire [7:0] matrix_column_in_i,
  output reg [17:0] matrix_row_out_o,
  output reg [17:0] matrix_row_oe_n_o,
  // System
  input wire bus_clock_stopped_i,
  output wire scan_runtime_irq_o,
  output reg scan_wake_request_o,
  output reg clock_request_status_set_o,
  output wire sleep_inhibit_o
);

  reg [7:0] row_sel;
  reg [7:0] col_enable;
  reg predrive_en;
  reg irq_armed;
  reg raw_irq_prev;
  reg [7:0] prev_enable;
  reg [1:0] clk_stop_sync;
  reg [4:0] predrive_cnt;
  reg [4:0] prev_select;
  reg drive_level;
  reg [31:0] read_value;
  wire [17:0] active_rows;
  wire [17:0] next_row_out;
  wire [17:0] next_row_oe_n;
  wire [7:0] col_sync;
  wire [7:0] col_status;
  wire [7:0] fall;
  wire [7:0] col_request;
  wire [7:0] wake_edge;
  wire status_write;
  wire rearm;
  wire predrive_active;
  wire scan_disable;
  wire scanning;
  wire raw_irq;
  wire sleeping;
  wire sel_over;
  wire [31:0] row_sel_word;
  genvar c;
  genvar r;

  assign scan_disable = row_sel[`SCAN_DIS_BIT];
  assign sel_over = row_sel[`SEL_MSB:`SEL_LSB] > `SEL_LAST_ROW;
  assign sleeping = clk_stop_sync[1];
  assign raw_irq = |col_request;
  // Once it falls, the line stays low until the columns all return high or the
  // condition changes, so a held key cannot retrigger the processor.
  assign scan_runtime_irq_o = raw_irq & irq_armed & ~sleeping;
  // Idle means no key down and no predrive running; the block then never
  // holds off chip sleep.
  assign scanning = ~scan_disable & (|(~col_sync) | (predrive_cnt != 5'h00));
  assign sleep_inhibit_o = scanning;
  assign row_sel_word = {24'h000000, row_sel};
  assign status_write = reg_wr_i && reg_addr_i == `OFS_COL_STATUS;
  // A new edge or an enable change rearms, as does every column returning high.
  // Without it a changed condition could never interrupt again.
  assign rearm = (&col_sync) | (|fall) | (col_enable != prev_enable);
  assign predrive_active = predrive_en & (predrive_cnt != 5'h00);

  // Column synchroniser per pin; the first stage feeds only the second, and a
  // third stage holds the previous level for the edge detector. All stages
  // reset to the idle high level, so no false edge follows reset.
  generate
    for (c = 0; c < `COL_COUNT; c = c + 1) begin : g_column
      reg meta_bit;
      reg sync_bit;
      reg prev_bit;
      always @(posedge clock_i) begin
        if (sys_rst_i) begin
          meta_bit <= 1'b1;
          sync_bit <= 1'b1;
          prev_bit <= 1'b1;
        end else begin
          meta_bit <= matrix_column_in_i[c];
          sync_bit <= meta_bit;
          prev_bit <= sync_bit;
        end
      end
      assign col_sync[c] = sync_bit;
      // The block clock keeps running while the bus clock is stopped, so the
      // capture works through sleep.
      assign fall[c] = prev_bit & ~sync_bit;
      assign col_request[c] = col_status[c] & col_enable[c];
      assign wake_edge[c] = fall[c] & col_enable[c];
    end
  endgenerate

  // Sleep input synchroniser.
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      clk_stop_sync <= 2'h0;
    end else begin
      clk_stop_sync <= {clk_stop_sync[0], bus_clock_stopped_i};
    end
  end

  // Control registers; reserved and read-only offsets ignore writes.
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      row_sel <= `ROW_SELECT_RESET;
    end else if (reg_wr_i && reg_addr_i == `OFS_ROW_SELECT) begin
      row_sel <= reg_wdata_i[7:0];
    end
  end

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      col_enable <= 8'h00;
    end else if (reg_wr_i && reg_addr_i == `OFS_COL_ENABLE) begin
      col_enable <= reg_wdata_i[7:0];
    end
  end

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      predrive_en <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == `OFS_EXT_CONTROL) begin
      predrive_en <= reg_wdata_i[`PREDRIVE_BIT];
    end
  end

  // One status flop per column; a new edge in the same cycle as a clear wins,
  // so a key that lands during the clear is never lost.
  generate
    for (c = 0; c < `COL_COUNT; c = c + 1) begin : g_status
      reg status_bit;
      always @(posedge clock_i) begin
        if (sys_rst_i) begin
          status_bit <= 1'b0;
        end else if (fall[c]) begin
          status_bit <= 1'b1;
        end else if (status_write && reg_wdata_i[c]) begin
          status_bit <= 1'b0;
        end
      end
      assign col_status[c] = status_bit;
    end
  endgenerate

  // Rearm state for the runtime interrupt.
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      irq_armed <= 1'b1;
      raw_irq_prev <= 1'b0;
      prev_enable <= 8'h00;
    end else begin
      raw_irq_prev <= raw_irq;
      prev_enable <= col_enable;
      if (rearm) begin
        irq_armed <= 1'b1;
      end else if (raw_irq_prev && !raw_irq) begin
        irq_armed <= 1'b0;
      end
    end
  end

  // Wake request holds until the bus clock runs again; the pulse marks each
  // enabled sleep-time edge for the clock-request status register.
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      scan_wake_request_o <= 1'b0;
      clock_request_status_set_o <= 1'b0;
    end else begin
      clock_request_status_set_o <= sleeping & (|wake_edge);
      if (!sleeping) begin
        scan_wake_request_o <= 1'b0;
      end else if (|wake_edge) begin
        scan_wake_request_o <= 1'b1;
      end
    end
  end

  // Row polarity; above the last row, with the all-rows bit clear, the sense is reversed.
  always @* begin
    if (sel_over && !row_sel[`ALL_ROWS_BIT]) begin
      drive_level = ~row_sel[`POLARITY_BIT];
    end else begin
      drive_level = row_sel[`POLARITY_BIT];
    end
  end
  generate
    for (r = 0; r < `ROW_COUNT; r = r + 1) begin : g_decode
      localparam [4:0] ROW_CODE = r;
      assign active_rows[r] = row_sel[`ALL_ROWS_BIT] | sel_over |
        (row_sel[`SEL_MSB:`SEL_LSB] == ROW_CODE);
    end
  endgenerate

  // Predrive timer restarts when the selected row changes with predrive enabled and scan not disabled.
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      predrive_cnt <= 5'h00;
      prev_select <= 5'h00;
    end else begin
      prev_select <= row_sel[`SEL_MSB:`SEL_LSB];
      if (predrive_en && !scan_disable && prev_select != row_sel[`SEL_MSB:`SEL_LSB]) begin
        predrive_cnt <= `PREDRIVE_CYCLES;
      end else if (predrive_cnt != 5'h00) begin
        predrive_cnt <= predrive_cnt - 5'h01;
      end
    end
  end

  // Inactive rows float on pull-ups; with predrive they are first pushed high
  // so they recover fast, at the cost of needing push-pull pads.
  generate
    for (r = 0; r < `ROW_COUNT; r = r + 1) begin : g_drive
      reg out_bit;
      reg oe_n_bit;
      always @* begin
        if (scan_disable) begin
          out_bit = 1'b1;
          oe_n_bit = 1'b1;
        end else if (active_rows[r]) begin
          out_bit = drive_level;
          oe_n_bit = drive_level & ~predrive_en;
        end else begin
          out_bit = 1'b1;
          oe_n_bit = ~predrive_active;
        end
      end
      assign next_row_out[r] = out_bit;
      assign next_row_oe_n[r] = oe_n_bit;
    end
  endgenerate

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      matrix_row_out_o <= 18'h3FFFF;
      matrix_row_oe_n_o <= 18'h3FFFF;
    end else begin
      matrix_row_out_o <= next_row_out;
      matrix_row_oe_n_o <= next_row_oe_n;
    end
  end

  // Read decode; unmapped and reserved offsets read zero.
  always @* begin
    if (reg_addr_i == `OFS_ROW_SELECT) begin
      read_value = row_sel_word;
    end else if (reg_addr_i == `OFS_COL_LEVEL) begin
      read_value = {24'h000000, col_sync};
    end else if (reg_addr_i == `OFS_COL_STATUS) begin
      read_value = {24'h000000, col_status};
    end else if (reg_addr_i == `OFS_COL_ENABLE) begin
      read_value = {24'h000000, col_enable};
    end else if (reg_addr_i == `OFS_EXT_CONTROL) begin
      read_value = {31'h00000000, predrive_en};
    end else begin
      read_value = 32'h00000000;
    end
  end

  // Read data is registered and holds until the next read strobe.
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= read_value;
    end
  end

endmodule
`default_nettype wire

// ==== verif/kbd_scan_props.sv ====
// Port checker for the keyboard matrix scanner, attached by bind.
// Assumes one-cycle register strobes and a two-stage sync on the sleep input.
`timescale 1ns/1ns
`default_nettype none
module kbd_scan_props (
  // Clock, reset and register port
  input wire clock_i, input wire sys_rst_i, input wire reg_wr_i, input wire reg_rd_i,
  input wire [5:0] reg_addr_i, input wire [31:0] reg_wdata_i, input wire [31:0] reg_rdata_o,
  // Pins and system
  input wire [17:0] matrix_row_oe_n_o, input wire bus_clock_stopped_i,
  input wire scan_runtime_irq_o, input wire scan_wake_request_o,
  input wire clock_request_status_set_o, input wire sleep_inhibit_o
);
  wire [7:0] wdata_low = reg_wdata_i[7:0];
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  chk_reserved_zero: assert property (reg_rd_i && reg_addr_i == 6'h00 |=> !reg_rdata_o)
    else $error("reserved read nonzero");
  chk_rdata_held: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved");
  chk_enable_back: assert property (reg_wr_i && reg_addr_i == 6'h10 ##1 reg_rd_i
    && reg_addr_i == 6'h10 |=> reg_rdata_o[7:0] == $past(wdata_low, 2)) else $error("enable readback");
  chk_rows_off: assert property (reg_wr_i && reg_addr_i == 6'h04 && reg_wdata_i[6]
    |-> ##2 (&matrix_row_oe_n_o && !sleep_inhibit_o)) else $error("rows not released");
  // The sleep input passes two sync stages, so four steady cycles are just enough.
  chk_wake_cleared: assert property (!bus_clock_stopped_i [*4] |-> !scan_wake_request_o)
    else $error("wake held while running");
  chk_irq_quiet_sleep: assert property (bus_clock_stopped_i [*4] |-> !scan_runtime_irq_o)
    else $error("irq during sleep");
  chk_pulse_single: assert property (clock_request_status_set_o |=> !clock_request_status_set_o)
    else $error("status pulse too long");
  chk_pulse_wake: assert property (clock_request_status_set_o |-> scan_wake_request_o)
    else $error("pulse without wake");
  cover property (scan_wake_request_o ##1 !scan_wake_request_o);
  cover property ($rose(scan_runtime_irq_o));
  cover property (clock_request_status_set_o);
endmodule
bind keyboard_matrix_scanner kbd_scan_props u_props (.clock_i, .sys_rst_i, .reg_wr_i, .reg_rd_i,
  .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .matrix_row_oe_n_o, .bus_clock_stopped_i,
  .scan_runtime_irq_o, .scan_wake_request_o, .clock_request_status_set_o, .sleep_inhibit_o);
`default_nettype wire

// ==== verif/key_matrix_model.sv ====
// Passive key matrix with pull-ups on rows and columns; one row of keys held.
// Assumes the scanner's row level and low-active row enable pins.
`timescale 1ns/1ns
`default_nettype none
module key_matrix_model (
  // Row pins, held keys and column pins
  input wire [17:0] row_out_i, input wire [17:0] row_oe_n_i,
  input wire [4:0] key_row_i, input wire [7:0] key_cols_i, output wire [7:0] column_o
);
  // A released row floats up, so only a row driven low can pull a column down.
  wire [17:0] row_level = row_out_i | row_oe_n_i;
  assign column_o = row_level[key_row_i] ? 8'hFF : ~key_cols_i;
endmodule
`default_nettype wire

// ==== verif/keyboard_matrix_scanner_test.sv ====
// Self-checking bench for the keyboard matrix scanner with a key matrix model.
// Assumes the scanner, its defines header, the model and the checker compile first.
`timescale 1ns/1ns
`default_nettype none
`include "kbd_scan_defs.vh"
module keyboard_matrix_scanner_test;
  logic clock_i = 1'h0, sys_rst_i = 1'h1, reg_wr_i = 1'h0, reg_rd_i = 1'h0, stopped = 1'h0;
  logic [5:0] reg_addr_i = 6'h00;
  logic [31:0] reg_wdata_i = 32'h0, d;
  logic [7:0] key_cols = 8'h04;
  wire [31:0] reg_rdata_o;
  wire [7:0] cols;
  wire [17:0] rows, oe_n;
  wire irq, wake, pulse, inhibit;
  wire [31:0] flags = {29'h0, irq, wake, inhibit};
  wire [31:0] row_lvl = {14'h0, rows | oe_n};
  int n_errors = 0, checks_done = 0;
  always #4 clock_i = ~clock_i;
  keyboard_matrix_scanner dut (.clock_i, .sys_rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .matrix_column_in_i(cols), .matrix_row_out_o(rows),
    .matrix_row_oe_n_o(oe_n), .bus_clock_stopped_i(stopped), .scan_runtime_irq_o(irq),
    .scan_wake_request_o(wake), .clock_request_status_set_o(pulse), .sleep_inhibit_o(inhibit));
  key_matrix_model matrix (.row_out_i(rows), .row_oe_n_i(oe_n), .key_row_i(5'h03),
    .key_cols_i(key_cols), .column_o(cols));
  task check(input [31:0] seen, input [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input [5:0] a, input [31:0] v);
    @(negedge clock_i);
    reg_wr_i = 1'h1;
    reg_addr_i = a;
    reg_wdata_i = v;
    @(negedge clock_i);
    reg_wr_i = 1'h0;
  endtask
  // Starts at a falling edge, so a read may follow a write in the next cycle.
  task rdchk(input [5:0] a, input [31:0] exp, input string what);
    reg_rd_i = 1'h1;
    reg_addr_i = a;
    @(negedge clock_i);
    reg_rd_i = 1'h0;
    check(reg_rdata_o, exp, what);
    @(negedge clock_i);
  endtask
  task t_reset;
    rdchk(`OFS_ROW_SELECT, 32'h00000040, "row select");
    check(row_lvl | {14'h0, oe_n}, 32'h0003FFFF, "rows off");
    check(flags, 32'h0, "flags idle");
    rdchk(`OFS_RESERVED, 32'h0, "reserved");
    $display("reset test done");
  endtask
  task t_scan;
    wr(`OFS_ROW_SELECT, 32'h00000040);
    wr(`OFS_EXT_CONTROL, 32'h00000001);
    rdchk(`OFS_EXT_CONTROL, 32'h00000001, "predrive");
    wr(`OFS_ROW_SELECT, 32'h00000003);
    repeat (4) @(negedge clock_i);
    check(row_lvl, 32'h0003FFF7, "row three");
    rdchk(`OFS_COL_LEVEL, 32'h000000FB, "columns");
    wr(`OFS_ROW_SELECT, 32'h00000092);
    repeat (4) @(negedge clock_i);
    check(row_lvl, 32'h0, "all rows low");
    rdchk(`OFS_COL_STATUS, 32'h00000004, "status");
    wr(`OFS_COL_ENABLE, 32'h00000004);
    rdchk(`OFS_COL_ENABLE, 32'h00000004, "enable");
    check(flags, 32'h5, "irq raised");
    wr(`OFS_COL_STATUS, 32'h0);
    rdchk(`OFS_COL_STATUS, 32'h00000004, "status kept");
    wr(`OFS_COL_STATUS, 32'h00000004);
    rdchk(`OFS_COL_STATUS, 32'h0, "status cleared");
    check(flags, 32'h1, "irq dropped");
    wr(`OFS_ROW_SELECT, 32'h00000040);
    wr(`OFS_EXT_CONTROL, 32'h0);
    rdchk(`OFS_EXT_CONTROL, 32'h0, "predrive off");
    wr(`OFS_ROW_SELECT, 32'h00000092);
    $display("scan test done");
  endtask
  task t_wake;
    key_cols = 8'h00;
    stopped = 1'h1;
    repeat (4) @(negedge clock_i);
    key_cols = 8'h04;
    d = 32'h0;
    repeat (8) begin
      @(negedge clock_i);
      d = d + {31'h0, pulse};
    end
    check(d, 32'h1, "request pulses");
    check(flags, 32'h3, "wake raised");
    stopped = 1'h0;
    repeat (5) @(negedge clock_i);
    check(flags, 32'h5, "resumed");
    $display("wake test done");
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clock_i);
    sys_rst_i = 1'h0;
    t_reset;
    t_scan;
    t_wake;
    wrap_up;
  end
  initial begin
    repeat (2000) @(posedge clock_i);
    n_errors++;
    wrap_up;
  end
endmodule
`default_nettype wire
